/* include/sxh_cfg.svh */
// Constants for the two-wire sensor bus controller.
`ifndef SXH_CFG_SVH
`define SXH_CFG_SVH

// -----------------------------------------------------------------------------
// Bus constants
// -----------------------------------------------------------------------------
`define SXH_TARGET_ADDR 7'h57
`define SXH_DIR_WRITE 1'b0
`define SXH_DIR_READ 1'b1
`define SXH_BITS_PER_BYTE 4'h8
`define SXH_MSB 3'h7
`define SXH_MAX_RETRY 4'h3

// -----------------------------------------------------------------------------
// Timing: quarter of a 400 kHz bit, 625 ns, at 40 MHz clock (25 ns).
// -----------------------------------------------------------------------------
`define SXH_SCL_HZ 400000
`define SXH_MCLK_HZ 40000000
`define SXH_QTR_CYC ((`SXH_MCLK_HZ + 4 * `SXH_SCL_HZ - 1) / (4 * `SXH_SCL_HZ))
`define SXH_QTR_W 8

`endif

/* include/sxh_pkg.sv */
// Types for the two-wire sensor bus controller.
package sxh_pkg;

  // Bit-level engine states, one-hot.
  typedef enum logic [6:0] {
    SXH_B_IDLE  = 7'h01,
    SXH_B_START = 7'h02,
    SXH_B_BIT   = 7'h04,
    SXH_B_STOP  = 7'h08,
    SXH_B_RSTRT = 7'h10,
    SXH_B_DONE  = 7'h20,
    SXH_B_HOLD  = 7'h40
  } sxh_bit_e;

  // Transaction states, one-hot.
  typedef enum logic [7:0] {
    SXH_T_IDLE  = 8'h01,
    SXH_T_ADDRW = 8'h02,
    SXH_T_REG   = 8'h04,
    SXH_T_WDATA = 8'h08,
    SXH_T_RSTRT = 8'h10,
    SXH_T_ADDRR = 8'h20,
    SXH_T_RDATA = 8'h40,
    SXH_T_STOP  = 8'h80
  } sxh_txn_e;

  // Bit engine commands.
  typedef enum logic [2:0] {
    SXH_C_START = 3'h0,
    SXH_C_BYTEW = 3'h1,
    SXH_C_BYTER = 3'h2,
    SXH_C_STOP  = 3'h3,
    SXH_C_RSTRT = 3'h4
  } sxh_cmd_e;

endpackage

/* logic/sxh_bit.sv */
// Bit engine: START, STOP, repeated START and nine-bit byte frames.
`timescale 1ns/1ps
`default_nettype none
`include "sxh_cfg.svh"

module sxh_bit (
  // Clock and control
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  // Command side
  input wire logic cmd_valid,
  input wire sxh_pkg::sxh_cmd_e cmd,
  input wire logic [7:0] tx_byte,
  input wire logic tx_ack_n,
  output logic done,
  output logic [7:0] rx_byte,
  output logic rx_ack_n,
  output logic busy,
  // Synchronised SDA level
  input wire logic sda_s,
  // Line drive, enables low while pulling low
  output logic scl_oe_n,
  output logic sda_oe_n
);

  sxh_pkg::sxh_bit_e st_q;
  sxh_pkg::sxh_cmd_e cmd_q;
  logic [`SXH_QTR_W-1:0] tick_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [8:0] sh_q;
  logic qtr;

  assign qtr = (tick_q == `SXH_QTR_W'(`SXH_QTR_CYC - 1));
  assign busy = (st_q != sxh_pkg::SXH_B_IDLE) && (st_q != sxh_pkg::SXH_B_HOLD);

  // Quarter-bit timer paces every phase at 400 kHz. The idle clear sits
  // under the enable too, so a frozen block keeps its timer untouched.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      tick_q <= '0;
    else if (ce)
      tick_q <= (qtr || !busy) ? '0 : tick_q + 1'b1;
  end

  // Phase sequencing; each condition and each data bit uses four quarters. Between commands SCL
  // is held low (HOLD), except after STOP, so the target never sees a stray condition.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_q <= sxh_pkg::SXH_B_IDLE;
      cmd_q <= sxh_pkg::SXH_C_STOP;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 9'h1ff;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      done <= 1'b0;
      rx_byte <= 8'h00;
      rx_ack_n <= 1'b1;
    end
    else if (ce)
    begin
      done <= 1'b0;
      case (st_q)
        sxh_pkg::SXH_B_IDLE, sxh_pkg::SXH_B_HOLD:
        begin
          if (cmd_valid)
          begin
            cmd_q <= cmd;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            sh_q <= (cmd == sxh_pkg::SXH_C_BYTER) ? {8'hff, tx_ack_n} : {tx_byte, 1'b1};
            case (cmd)
              sxh_pkg::SXH_C_START: st_q <= sxh_pkg::SXH_B_START;
              sxh_pkg::SXH_C_STOP: st_q <= sxh_pkg::SXH_B_STOP;
              sxh_pkg::SXH_C_RSTRT: st_q <= sxh_pkg::SXH_B_RSTRT;
              default: st_q <= sxh_pkg::SXH_B_BIT;
            endcase
          end
        end
        sxh_pkg::SXH_B_START:
        begin
          // SDA falls mid SCL-high, SCL falls afterwards.
          if (qtr)
          begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: sda_oe_n <= 1'b1;
              2'h1: sda_oe_n <= 1'b0;
              2'h2: scl_oe_n <= 1'b0;
              default: st_q <= sxh_pkg::SXH_B_DONE;
            endcase
          end
        end
        sxh_pkg::SXH_B_RSTRT:
        begin
          // Release SDA with SCL low, raise SCL, then pull SDA: new start.
          if (qtr)
          begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: sda_oe_n <= 1'b1;
              2'h1: scl_oe_n <= 1'b1;
              2'h2: sda_oe_n <= 1'b0;
              default:
              begin
                scl_oe_n <= 1'b0;
                st_q <= sxh_pkg::SXH_B_DONE;
              end
            endcase
          end
        end
        sxh_pkg::SXH_B_STOP:
        begin
          // SDA low, SCL up, then SDA rises; any following start pulls SDA at
          // least three quarters later, within the same SCL high interval.
          if (qtr)
          begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: sda_oe_n <= 1'b0;
              2'h1: scl_oe_n <= 1'b1;
              2'h2: sda_oe_n <= 1'b1;
              default: st_q <= sxh_pkg::SXH_B_DONE;
            endcase
          end
        end
        sxh_pkg::SXH_B_BIT:
        begin
          // Data changes with SCL low and holds through SCL high.
          if (qtr)
          begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: sda_oe_n <= sh_q[8];
              2'h1: scl_oe_n <= 1'b1;
              2'h2: sh_q <= {sh_q[7:0], sda_s};
              default:
              begin
                scl_oe_n <= 1'b0;
                bit_q <= bit_q + 4'h1;
                if (bit_q == `SXH_BITS_PER_BYTE)
                begin
                  rx_byte <= sh_q[8:1];
                  rx_ack_n <= sh_q[0];
                  st_q <= sxh_pkg::SXH_B_DONE;
                end
              end
            endcase
          end
        end
        default:
        begin
          // Report completion; leave SCL low unless the bus was freed.
          done <= 1'b1;
          if (cmd_q == sxh_pkg::SXH_C_STOP)
            st_q <= sxh_pkg::SXH_B_IDLE;
          else
          begin
            sda_oe_n <= (cmd_q == sxh_pkg::SXH_C_BYTEW || cmd_q == sxh_pkg::SXH_C_BYTER) ?
                        1'b0 : sda_oe_n;
            st_q <= sxh_pkg::SXH_B_HOLD;
          end
        end
      endcase
    end
  end

endmodule // sxh_bit

`default_nettype wire

/* logic/sxh_host.sv */
// Controller that writes and reads the sensor register bank over two wires.
`timescale 1ns/1ps
`default_nettype none
`include "sxh_cfg.svh"

module sxh_host (
  // Clock and control
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  // Request side
  input wire logic req_valid,
  input wire logic req_read,
  input wire logic [7:0] req_reg,
  input wire logic [7:0] req_len,
  output logic req_ready,
  // Write data, one byte per wr_take pulse
  input wire logic [7:0] wr_data,
  output logic wr_take,
  // Read data
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Completion
  output logic txn_done,
  output logic txn_err,
  // Serial clock pin
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  // Serial data pin
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] sda_sync_q;
  logic [1:0] scl_sync_q;
  logic scl_seen_q;

  // Two flops on each pin; only the second stage is read.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sda_sync_q <= 2'h3;
      scl_sync_q <= 2'h3;
    end
    else if (ce)
    begin
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_sync_q <= {scl_sync_q[0], scl_i};
    end
  end

  // ---------------------------------------------------------------------------
  // Bit engine
  // ---------------------------------------------------------------------------
  logic cmd_valid_q;
  sxh_pkg::sxh_cmd_e cmd_q;
  logic [7:0] tx_q;
  logic tx_ack_n_q;
  logic b_done;
  logic [7:0] b_rx;
  logic b_ack_n;
  logic b_scl_oe_n;
  logic b_sda_oe_n;

  sxh_bit u_bit (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .cmd_valid(cmd_valid_q),
    .cmd(cmd_q),
    .tx_byte(tx_q),
    .tx_ack_n(tx_ack_n_q),
    .done(b_done),
    .rx_byte(b_rx),
    .rx_ack_n(b_ack_n),
    .busy(),
    .sda_s(sda_sync_q[1]),
    .scl_oe_n(b_scl_oe_n),
    .sda_oe_n(b_sda_oe_n)
  );

  // Pins are open drain: output level is always low, enable low pulls.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      scl_oe_n <= b_scl_oe_n;
      sda_oe_n <= b_sda_oe_n;
    end
  end

  // ---------------------------------------------------------------------------
  // Transaction sequencer
  // ---------------------------------------------------------------------------
  sxh_pkg::sxh_txn_e st_q;
  logic rd_q;
  logic [7:0] reg_q;
  logic [7:0] left_q;
  logic [3:0] retry_q;
  logic wait_q;
  logic err_q;

  // Address byte: seven target bits then the direction bit, MSB first.
  function automatic logic [7:0] addr_byte(input logic dir);
    addr_byte = {`SXH_TARGET_ADDR, dir};
  endfunction

  // Issue a bit-engine command and wait for its completion.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_q <= sxh_pkg::SXH_T_IDLE;
      cmd_valid_q <= 1'b0;
      cmd_q <= sxh_pkg::SXH_C_STOP;
      tx_q <= 8'h00;
      tx_ack_n_q <= 1'b1;
      rd_q <= 1'b0;
      reg_q <= 8'h00;
      left_q <= 8'h00;
      retry_q <= 4'h0;
      wait_q <= 1'b0;
      err_q <= 1'b0;
      req_ready <= 1'b0;
      wr_take <= 1'b0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      txn_done <= 1'b0;
      txn_err <= 1'b0;
    end
    else if (ce)
    begin
      cmd_valid_q <= 1'b0;
      wr_take <= 1'b0;
      rd_valid <= 1'b0;
      txn_done <= 1'b0;
      req_ready <= 1'b0;
      case (st_q)
        sxh_pkg::SXH_T_IDLE:
        begin
          req_ready <= !req_valid && scl_seen_q && sda_sync_q[1];
          if (req_valid && req_ready)
          begin
            rd_q <= req_read;
            reg_q <= req_reg;
            left_q <= (req_len == 8'h00) ? 8'h01 : req_len;
            retry_q <= 4'h0;
            err_q <= 1'b0;
            req_ready <= 1'b0;
            // Every access, read or write, opens with a write phase.
            cmd_q <= sxh_pkg::SXH_C_START;
            cmd_valid_q <= 1'b1;
            wait_q <= 1'b1;
            st_q <= sxh_pkg::SXH_T_ADDRW;
          end
        end
        default:
        begin
          if (!wait_q)
          begin
            cmd_valid_q <= 1'b1;
            wait_q <= 1'b1;
          end
          else if (b_done)
          begin
            wait_q <= 1'b0;
            case (st_q)
              sxh_pkg::SXH_T_ADDRW:
              begin
                if (cmd_q == sxh_pkg::SXH_C_START)
                begin
                  cmd_q <= sxh_pkg::SXH_C_BYTEW;
                  tx_q <= addr_byte(`SXH_DIR_WRITE);
                end
                else if (b_ack_n)
                begin
                  // No acknowledge: free the bus and try again.
                  err_q <= 1'b1;
                  cmd_q <= sxh_pkg::SXH_C_STOP;
                  st_q <= sxh_pkg::SXH_T_STOP;
                end
                else
                begin
                  tx_q <= reg_q;
                  st_q <= sxh_pkg::SXH_T_REG;
                end
              end
              sxh_pkg::SXH_T_REG, sxh_pkg::SXH_T_WDATA:
              begin
                if (b_ack_n)
                begin
                  err_q <= 1'b1;
                  cmd_q <= sxh_pkg::SXH_C_STOP;
                  st_q <= sxh_pkg::SXH_T_STOP;
                end
                else if (rd_q)
                begin
                  cmd_q <= sxh_pkg::SXH_C_RSTRT;
                  st_q <= sxh_pkg::SXH_T_RSTRT;
                end
                else if (st_q == sxh_pkg::SXH_T_WDATA && left_q == 8'h01)
                begin
                  cmd_q <= sxh_pkg::SXH_C_STOP;
                  st_q <= sxh_pkg::SXH_T_STOP;
                end
                else
                begin
                  // Target fills consecutive registers from the pointer.
                  if (st_q == sxh_pkg::SXH_T_WDATA)
                    left_q <= left_q - 8'h01;
                  tx_q <= wr_data;
                  wr_take <= 1'b1;
                  st_q <= sxh_pkg::SXH_T_WDATA;
                end
              end
              sxh_pkg::SXH_T_RSTRT:
              begin
                cmd_q <= sxh_pkg::SXH_C_BYTEW;
                tx_q <= addr_byte(`SXH_DIR_READ);
                st_q <= sxh_pkg::SXH_T_ADDRR;
              end
              sxh_pkg::SXH_T_ADDRR:
              begin
                if (b_ack_n)
                begin
                  err_q <= 1'b1;
                  cmd_q <= sxh_pkg::SXH_C_STOP;
                  st_q <= sxh_pkg::SXH_T_STOP;
                end
                else
                begin
                  // Acknowledge all but the final byte.
                  cmd_q <= sxh_pkg::SXH_C_BYTER;
                  tx_ack_n_q <= (left_q == 8'h01);
                  st_q <= sxh_pkg::SXH_T_RDATA;
                end
              end
              sxh_pkg::SXH_T_RDATA:
              begin
                // Bytes come from successive registers, or repeat the FIFO.
                rd_data <= b_rx;
                rd_valid <= 1'b1;
                left_q <= left_q - 8'h01;
                if (left_q == 8'h01)
                begin
                  cmd_q <= sxh_pkg::SXH_C_STOP;
                  st_q <= sxh_pkg::SXH_T_STOP;
                end
                else
                  tx_ack_n_q <= (left_q == 8'h02);
              end
              default:
              begin
                // Bus freed; retry a refused transfer a bounded number of times.
                if (err_q && retry_q != `SXH_MAX_RETRY)
                begin
                  retry_q <= retry_q + 4'h1;
                  err_q <= 1'b0;
                  cmd_q <= sxh_pkg::SXH_C_START;
                  st_q <= sxh_pkg::SXH_T_ADDRW;
                end
                else
                begin
                  txn_done <= 1'b1;
                  txn_err <= err_q;
                  st_q <= sxh_pkg::SXH_T_IDLE;
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  // Settled clock-line level; a request is only taken while the bus rests
  // high, so a line held low by a fault never gets a start squeezed in.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      scl_seen_q <= 1'b1;
    else if (ce)
      scl_seen_q <= scl_sync_q[1];
  end

endmodule // sxh_host

`default_nettype wire

/* sim/sxh_dev_model.sv */
// Behavioural sensor target on the two-wire bus, with a register bank.
`timescale 1ns/1ps
`default_nettype none

module sxh_dev_model #(
  parameter logic [7:0] FIFO_REG = 8'h05
) (
  // Bus levels
  input wire logic scl,
  input wire logic sda,
  // Address answered
  input wire logic [6:0] dev_addr,
  // Data pull, low drives the line low
  output logic sda_oe_n
);
  logic [7:0] mem [0:255];
  logic [7:0] ptr = 8'h00;
  logic [7:0] sh = 8'h00;
  logic [7:0] rb = 8'h00;
  logic [7:0] fifo_q = 8'h80;
  logic [3:0] bitc = 4'h0;
  int ph = 0;
  int starts = 0;
  int nacks = 0;

  // Known contents, so a read never puts an unknown on the line.
  initial
  begin
    sda_oe_n = 1'b1;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
  end

  // Start or repeated start opens an address phase; the pointer survives it.
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      ph = 1;
      bitc = 4'h0;
      starts++;
      sda_oe_n = 1'b1;
    end

  // A stop at any bit ends the transfer.
  always @(posedge sda)
    if (scl === 1'b1)
    begin
      ph = 0;
      sda_oe_n = 1'b1;
    end

  // Sample on the rising clock: ph 1 address, 2 register, 3 write, 4 read, 5 wait.
  always @(posedge scl)
    if (ph != 0 && ph != 5)
    begin
      if (bitc == 4'h8)
      begin
        if (ph == 4 && sda === 1'b1)
        begin
          ph = 5;
          nacks++;
        end
        bitc = 4'h0;
      end
      else
      begin
        sh = {sh[6:0], sda};
        if (ph == 1 && bitc < 4'h7 && sda !== dev_addr[3'h6 - bitc[2:0]])
          ph = 0;
        bitc++;
      end
    end

  // Drive on the falling clock, so the line is settled before the next rise.
  always @(negedge scl)
    if (ph != 0 && ph != 5)
    begin
      sda_oe_n = 1'b1;
      if (bitc == 4'h8 && ph != 4)
      begin
        sda_oe_n = 1'b0;
        if (ph == 3)
        begin
          mem[ptr] = sh;
          ptr++;
        end
        if (ph == 2)
          ptr = sh;
        ph = (ph == 1) ? (sh[0] ? 4 : 2) : 3;
      end
      else if (ph == 4 && bitc == 4'h0)
      begin
        if (ptr == FIFO_REG)
        begin
          rb = fifo_q;
          fifo_q++;
        end
        else
        begin
          rb = mem[ptr];
          ptr++;
        end
        sda_oe_n = rb[7];
      end
      else if (ph == 4 && bitc != 4'h8)
        sda_oe_n = rb[3'h7 - bitc[2:0]];
    end
endmodule // sxh_dev_model

`default_nettype wire

/* sim/sxh_host_sva.sv */
// Port-level protocol checks for the two-wire sensor bus controller.
`timescale 1ns/1ps
`default_nettype none

module sxh_host_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Request and completion
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rd_valid,
  input wire logic txn_done,
  input wire logic txn_err,
  // Pin drive
  input wire logic scl_o,
  input wire logic sda_o,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n
);
  logic scl_p_q;
  logic [15:0] per_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // Previous clock-line drive, for spotting its release.
  always_ff @(posedge mclk)
    scl_p_q <= scl_oe_n;

  // Cycles since the clock line was last released; saturates over idle gaps.
  always_ff @(posedge mclk)
    if (sys_rst)
      per_q <= 16'hffff;
    else if (scl_oe_n && !scl_p_q)
      per_q <= 16'h0001;
    else if (per_q != 16'hffff)
      per_q <= per_q + 16'h0001;

  chk_idle_released:
    assert property (req_ready |-> scl_oe_n && sda_oe_n)
    else $error("line pulled while idle");
  chk_open_drain:
    assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("pin driven high");
  chk_req_start:
    assert property (req_valid && req_ready |-> ##[1:300] ($fell(sda_oe_n) && scl_oe_n))
    else $error("no start after request");
  chk_start_no_stop:
    assert property ($fell(sda_oe_n) && scl_oe_n |-> !sda_oe_n throughout (##[1:200] !scl_oe_n))
    else $error("stop in start high pulse");
  chk_stop_frees:
    assert property ($rose(sda_oe_n) && scl_oe_n && $past(scl_oe_n) |-> sda_oe_n [*8])
    else $error("bus not freed after stop");
  chk_err_with_done:
    assert property ($rose(txn_err) |-> txn_done)
    else $error("error flag without completion");
  chk_bit_period:
    assert property ($rose(scl_oe_n) |-> per_q >= 16'h0064)
    else $error("serial clock above 400 kHz");
  chk_scl_high_hold:
    assert property ($rose(scl_oe_n) |-> scl_oe_n [*8])
    else $error("clock high pulse too short");

  cover property (txn_done && !txn_err);
  cover property (txn_done && txn_err);
  cover property (rd_valid);
endmodule // sxh_host_sva

`default_nettype wire

/* sim/sxh_host_tb.sv */
// Self-checking bench for the two-wire sensor bus controller.
`timescale 1ns/1ps
`default_nettype none
`include "sxh_cfg.svh"

module sxh_host_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic req_valid = 1'b0;
  logic req_read = 1'b0;
  logic [7:0] req_reg = 8'h00;
  logic [7:0] req_len = 8'h01;
  logic [7:0] wr_data = 8'h00;
  logic [6:0] dev_addr = `SXH_TARGET_ADDR;
  logic [7:0] rd_data;
  logic req_ready, wr_take, rd_valid, txn_done, txn_err;
  logic scl_o, sda_o, scl_oe_n, sda_oe_n, dev_oe_n;
  wire logic scl_w;
  wire logic sda_w;
  logic [7:0] wbuf [0:7];
  logic [7:0] rq [$];
  int miscompares = 0;
  int compares = 0;
  int wi = 0;
  int takes = 0;
  int s0, n0;

  // 40 MHz system clock.
  always #12.5 mclk = ~mclk;

  // Pull-ups hold both lines high unless a party pulls low.
  assign scl_w = scl_oe_n;
  assign sda_w = sda_oe_n & dev_oe_n;

  sxh_host sxh_host_i (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .req_valid(req_valid),
    .req_read(req_read), .req_reg(req_reg), .req_len(req_len), .req_ready(req_ready),
    .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
    .txn_done(txn_done), .txn_err(txn_err), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
  sxh_dev_model sxh_dev_model_i (.scl(scl_w), .sda(sda_w), .dev_addr(dev_addr),
    .sda_oe_n(dev_oe_n));

  // Collect read bytes; hand the next write byte over after each take.
  always @(posedge mclk)
  begin
    if (rd_valid === 1'b1)
      rq.push_back(rd_data);
    if (wr_take === 1'b1)
    begin
      takes <= takes + 1;
      wi = wi + 1;
      wr_data <= wbuf[wi[2:0]];
    end
  end

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp1(input string what, input logic exp, input logic got);
    cmp8(what, {7'h00, exp}, {7'h00, got});
  endtask

  // One request, then a bounded wait for completion; flags are read settled.
  task automatic run(input logic rd, input logic [7:0] rg, input logic [7:0] n);
    int t;
    t = 0;
    while (req_ready !== 1'b1 && t < 1000)
    begin
      @(negedge mclk);
      t++;
    end
    @(posedge mclk);
    req_read <= rd;
    req_reg <= rg;
    req_len <= n;
    req_valid <= 1'b1;
    @(posedge mclk);
    req_valid <= 1'b0;
    while (txn_done !== 1'b1 && t < 40000)
    begin
      @(negedge mclk);
      t++;
    end
    cmp1("done", 1'b1, txn_done);
  endtask

  task automatic t_reset();
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    cmp1("ready in reset", 1'b0, req_ready);
    cmp1("scl in reset", 1'b1, scl_oe_n);
    cmp1("sda in reset", 1'b1, sda_oe_n);
    @(posedge mclk);
    sys_rst <= 1'b0;
    $display("reset test done");
  endtask

  task automatic t_write();
    wbuf[0] = 8'h3c;
    wbuf[1] = 8'ha5;
    wbuf[2] = 8'h0f;
    wi = 0;
    @(posedge mclk);
    takes <= 0;
    wr_data <= 8'h3c;
    run(1'b0, 8'h10, 8'h03);
    cmp1("write err", 1'b0, txn_err);
    cmp8("takes", 8'h03, 8'(takes));
    for (int i = 0; i < 3; i++)
      cmp8("stored", wbuf[i], sxh_dev_model_i.mem[16 + i]);
    cmp8("untouched", 8'h13 ^ 8'h5a, sxh_dev_model_i.mem[19]);
    $display("write test done");
  endtask

  task automatic t_read();
    rq.delete();
    s0 = sxh_dev_model_i.starts;
    n0 = sxh_dev_model_i.nacks;
    run(1'b1, 8'h10, 8'h03);
    cmp1("read err", 1'b0, txn_err);
    cmp8("read count", 8'h03, 8'(rq.size()));
    for (int i = 0; i < 3; i++)
      cmp8("read byte", wbuf[i], rq[i]);
    cmp8("starts", 8'h02, 8'(sxh_dev_model_i.starts - s0));
    cmp8("nacks", 8'h01, 8'(sxh_dev_model_i.nacks - n0));
    $display("read test done");
  endtask

  task automatic t_fifo();
    rq.delete();
    run(1'b1, 8'h05, 8'h04);
    for (int i = 0; i < 4; i++)
      cmp8("fifo byte", 8'h80 + 8'(i), rq[i]);
    cmp8("pointer", 8'h05, sxh_dev_model_i.ptr);
    run(1'b1, 8'h06, 8'h01);
    cmp8("after fifo", 8'h5c, rq[4]);
    $display("fifo test done");
  endtask

  task automatic t_nack();
    @(posedge mclk);
    dev_addr <= `SXH_TARGET_ADDR ^ 7'h01;
    s0 = sxh_dev_model_i.starts;
    run(1'b0, 8'h20, 8'h01);
    cmp1("nack err", 1'b1, txn_err);
    cmp8("tries", 8'h04, 8'(sxh_dev_model_i.starts - s0));
    cmp8("ignored", 8'h7a, sxh_dev_model_i.mem[32]);
    dev_addr <= `SXH_TARGET_ADDR;
    $display("nack test done");
  endtask

  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    t_reset();
    t_write();
    t_read();
    t_fifo();
    t_nack();
    conclude();
  end

  // The tests need about 26k cycles; a hang ends the run at 90k.
  initial
  begin
    repeat (90000) @(posedge mclk);
    miscompares++;
    conclude();
  end
endmodule // sxh_host_tb

bind sxh_host sxh_host_sva sxh_host_sva_i (.mclk(mclk), .sys_rst(sys_rst),
  .req_valid(req_valid), .req_ready(req_ready), .rd_valid(rd_valid), .txn_done(txn_done),
  .txn_err(txn_err), .scl_o(scl_o), .sda_o(sda_o), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n));

`default_nettype wire
